// *** pkg/prs_pkg.sv ***
`default_nettype none

package prs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ       = 64'd20_000_000;
  localparam longint unsigned LOCK_MS      = 64'd60;
  localparam int unsigned     LOCK_CYC_DEF = int'((LOCK_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned     CNT_W        = 21;
  localparam int unsigned     HOLD_CYC     = 16;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CLKRST = 8'h04;
  localparam logic [7:0] OFS_PGATE  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // CTRL fields
  localparam int unsigned CTRL_LP    = 0;
  localparam int unsigned CTRL_PWR18 = 1;
  localparam int unsigned CTRL_DRAM  = 2;

  // STATUS fields
  localparam int unsigned STAT_SENSE = 0;
  localparam int unsigned STAT_PLLR  = 1;
  localparam int unsigned STAT_CPUR  = 2;
  localparam int unsigned STAT_LP    = 3;
  localparam int unsigned STAT_ST    = 4;

  // Defaults
  localparam logic [7:0] CLKEN_RST = 8'h00;
  localparam logic [7:0] BLKREL_RST = 8'h00;
  localparam logic [7:0] PGATE_RST = 8'hff;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } prs_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } prs_wb_rsp_t;

  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] blk_rst;
    logic [7:0] pgate_en;
    logic       pwr18_en;
    logic       dram_init;
  } prs_dom_t;

endpackage

`default_nettype wire

// *** core/prs_sense_sync.sv ***
`default_nettype none

module prs_sense_sync
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Sense in
  input  wire logic sense_i,
  // Synchronized level and rising edge
  output logic      sense_o,
  output logic      rise_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } prs_sync_t;

  prs_sync_t q;
  prs_sync_t next_q;

  // First stage feeds only the second stage
  always_comb
  begin
    next_q    = q;
    next_q.s1 = sense_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign sense_o = q.s2;
  assign rise_o  = q.s2 & ~q.s3;

endmodule

`default_nettype wire

// *** core/prs_sequencer.sv ***
// Implementation choices: register access over Wishbone and the register addresses.
`default_nettype none

module prs_sequencer
#(
  parameter int unsigned LOCK_CYC = prs_pkg::LOCK_CYC_DEF
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Power monitor
  input  wire logic              power_on_sense_i,
  input  wire logic              supply_fail_warning_i,
  // System reset events and park handshake
  input  wire logic              sys_reset_req_i,
  input  wire logic              park_done_i,
  output logic                   park_req_o,
  // Wishbone slave
  input  wire prs_pkg::prs_wb_req_t wb_i,
  output prs_pkg::prs_wb_rsp_t   wb_o,
  // Reset and clock controls
  output logic                   master_pll_rst_o,
  output logic                   cpu_rst_o,
  output logic                   cpu_clk_en_o,
  output logic                   io_oe_o,
  output prs_pkg::prs_dom_t      dom_o
);

  import prs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    S_OFF,
    S_LOCK,
    S_RUN,
    S_PARK,
    S_HOLD
  } prs_st_t;

  typedef struct packed {
    prs_st_t          st;
    logic [CNT_W-1:0] cnt;
    logic             pll_rst;
    logic             cpu_rst;
    logic             cpu_clk;
    logic             io_oe;
    logic             park;
    logic             lp;
    prs_dom_t         dom;
    prs_wb_rsp_t      wb;
  } prs_state_t;

  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

  prs_state_t q;
  prs_state_t next_q;
  logic       sense_s;
  logic       sense_rise;
  logic       wb_hit;
  logic       wb_wr;

  prs_sense_sync u_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sense_i (power_on_sense_i),
    .sense_o (sense_s),
    .rise_o  (sense_rise)
  );

  // ****************************************
  // Domain defaults
  // ****************************************
  // Power-on always powers 1.8-V; a warm reset keeps it off after low power
  function automatic prs_dom_t dom_defaults(input logic keep_18v_off);
    prs_dom_t d;
    d.clk_en    = CLKEN_RST;
    d.blk_rst   = ~BLKREL_RST;
    d.pgate_en  = PGATE_RST;
    d.pwr18_en  = ~keep_18v_off;
    d.dram_init = 1'b0;
    return d;
  endfunction

  assign wb_hit = wb_i.cyc & wb_i.stb & ~q.wb.ack;
  assign wb_wr  = wb_hit & wb_i.we & (q.st == S_RUN);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_q        = q;
    next_q.wb.ack = wb_hit;
    next_q.wb.dat = '0;

    // Read path
    if (wb_hit && !wb_i.we)
    begin
      case (wb_i.adr)
        OFS_CTRL:
        begin
          next_q.wb.dat[CTRL_LP]    = q.lp;
          next_q.wb.dat[CTRL_PWR18] = q.dom.pwr18_en;
          next_q.wb.dat[CTRL_DRAM]  = q.dom.dram_init;
        end
        OFS_CLKRST:
          next_q.wb.dat[15:0] = {~q.dom.blk_rst, q.dom.clk_en};
        OFS_PGATE:
          next_q.wb.dat[7:0] = q.dom.pgate_en;
        OFS_STATUS:
        begin
          next_q.wb.dat[STAT_SENSE]        = sense_s;
          next_q.wb.dat[STAT_PLLR]         = q.pll_rst;
          next_q.wb.dat[STAT_CPUR]         = q.cpu_rst;
          next_q.wb.dat[STAT_LP]           = q.lp;
          next_q.wb.dat[STAT_ST+2:STAT_ST] = q.st;
        end
        default:
          next_q.wb.dat = '0;
      endcase
    end

    // Write path, only while the processor runs
    if (wb_wr)
    begin
      case (wb_i.adr)
        OFS_CTRL:
        begin
          if (wb_i.sel[0])
          begin
            next_q.lp = wb_i.dat[CTRL_LP];
            // Low power drops the 1.8-V domain and with it DRAM
            next_q.dom.pwr18_en = wb_i.dat[CTRL_PWR18] & ~wb_i.dat[CTRL_LP];
            // DRAM init only once clocks are up on 1.8-V
            next_q.dom.dram_init = wb_i.dat[CTRL_DRAM] & next_q.dom.pwr18_en
                                   & (|q.dom.clk_en);
          end
        end
        OFS_CLKRST:
        begin
          // Clock enables refused until 1.8-V is on
          if (wb_i.sel[0] && q.dom.pwr18_en)
            next_q.dom.clk_en = wb_i.dat[7:0];
          if (wb_i.sel[1])
            next_q.dom.blk_rst = ~wb_i.dat[15:8];
        end
        OFS_PGATE:
        begin
          if (wb_i.sel[0])
            next_q.dom.pgate_en = wb_i.dat[7:0];
        end
        default:
          next_q.lp = q.lp;
      endcase
      if (!next_q.dom.pwr18_en)
      begin
        next_q.dom.clk_en    = CLKEN_RST;
        next_q.dom.dram_init = 1'b0;
      end
    end

    // Sequencing
    case (q.st)
      S_OFF:
      begin
        if (sense_rise)
        begin
          next_q.st      = S_LOCK;
          next_q.pll_rst = 1'b0;
          next_q.cnt     = '0;
        end
      end
      S_LOCK:
      begin
        next_q.cnt = q.cnt + 1'b1;
        if (q.cnt == LOCK_LAST)
        begin
          next_q.st      = S_RUN;
          next_q.cpu_rst = 1'b0;
          next_q.cpu_clk = 1'b1;
          next_q.io_oe   = 1'b1;
          next_q.dom     = dom_defaults(1'b0);
        end
      end
      S_RUN:
      begin
        if (supply_fail_warning_i)
        begin
          next_q.st   = S_PARK;
          next_q.park = 1'b1;
        end
        else if (sys_reset_req_i)
        begin
          next_q.st      = S_HOLD;
          next_q.cnt     = '0;
          next_q.cpu_rst = 1'b1;
          next_q.dom     = dom_defaults(q.lp);
        end
      end
      S_PARK:
      begin
        // Reset waits for the mirrors to be parked
        if (park_done_i)
        begin
          next_q.st      = S_HOLD;
          next_q.park    = 1'b0;
          next_q.cnt     = '0;
          next_q.cpu_rst = 1'b1;
          next_q.dom     = dom_defaults(q.lp);
        end
      end
      S_HOLD:
      begin
        // Stays in reset while the warning persists
        if (supply_fail_warning_i)
          next_q.cnt = '0;
        else if (q.cnt == HOLD_LAST)
        begin
          next_q.st      = S_RUN;
          next_q.cpu_rst = 1'b0;
          next_q.lp      = 1'b0;
        end
        else
          next_q.cnt = q.cnt + 1'b1;
      end
      default:
        next_q.st = S_OFF;
    endcase

    // Sense low overrides everything except the Wishbone response
    if (!sense_s)
    begin
      next_q.st      = S_OFF;
      next_q.cnt     = '0;
      next_q.pll_rst = 1'b1;
      next_q.cpu_rst = 1'b1;
      next_q.cpu_clk = 1'b0;
      next_q.io_oe   = 1'b0;
      next_q.park    = 1'b0;
      next_q.lp      = 1'b0;
      next_q.dom     = dom_defaults(1'b0);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q         <= '0;
      q.st      <= S_OFF;
      q.pll_rst <= 1'b1;
      q.cpu_rst <= 1'b1;
      q.dom     <= {CLKEN_RST, ~BLKREL_RST, PGATE_RST, 1'b1, 1'b0};
    end
    else
      q <= next_q;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign master_pll_rst_o = q.pll_rst;
  assign cpu_rst_o        = q.cpu_rst;
  assign cpu_clk_en_o     = q.cpu_clk;
  assign io_oe_o          = q.io_oe;
  assign park_req_o       = q.park;
  assign dom_o            = q.dom;
  assign wb_o             = q.wb;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_full_reset;
    !sense_s |=> (master_pll_rst_o && cpu_rst_o && !cpu_clk_en_o);
  endproperty
  a_full_reset: assert property (p_full_reset)
    else $error("reset not held while sense low");

  property p_hiz;
    !sense_s |=> !io_oe_o ##0 !park_req_o;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pins driven while sense low");

  property p_pll_only;
    (q.st == S_OFF && sense_rise && sense_s) |=> !master_pll_rst_o && cpu_rst_o && !io_oe_o;
  endproperty
  a_pll_only: assert property (p_pll_only)
    else $error("release on sense rise not pll only");

  property p_lock_hold;
    (q.st == S_LOCK && q.cnt != LOCK_LAST && sense_s) |=> cpu_rst_o && !master_pll_rst_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("processor released before lock delay");

  property p_boot;
    (q.st == S_LOCK && q.cnt == LOCK_LAST && sense_s) |=> !cpu_rst_o && io_oe_o;
  endproperty
  a_boot: assert property (p_boot)
    else $error("processor not released at lock end");

  property p_normal;
    $fell(cpu_rst_o) |-> cpu_clk_en_o && !master_pll_rst_o;
  endproperty
  a_normal: assert property (p_normal)
    else $error("processor clock off at release");

  property p_defaults;
    $fell(cpu_rst_o) && $past(q.st) == S_LOCK
      |-> dom_o.clk_en == CLKEN_RST && dom_o.blk_rst == ~BLKREL_RST
          && dom_o.pgate_en == PGATE_RST && dom_o.pwr18_en;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("power-up defaults wrong");

  property p_warm;
    (q.st == S_RUN && sense_s && !supply_fail_warning_i && sys_reset_req_i)
      |=> cpu_rst_o && dom_o.clk_en == CLKEN_RST && dom_o.pgate_en == PGATE_RST
          && dom_o.pwr18_en == !$past(q.lp);
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm reset defaults wrong");

  property p_order;
    $rose(|dom_o.clk_en) |-> dom_o.pwr18_en ##0 $past(dom_o.pwr18_en);
  endproperty
  a_order: assert property (p_order)
    else $error("clocks enabled before 1.8-V");

  property p_park;
    (q.st == S_RUN && sense_s && supply_fail_warning_i) |=> park_req_o && !cpu_rst_o;
  endproperty
  a_park: assert property (p_park)
    else $error("warning did not start park");

  property p_park_reset;
    (park_req_o && park_done_i && sense_s) |=> cpu_rst_o && !park_req_o;
  endproperty
  a_park_reset: assert property (p_park_reset)
    else $error("no reset after park");

endmodule

`default_nettype wire

// *** verif/prs_pwr_monitor.sv ***
`default_nettype none

module prs_pwr_monitor
#(
  parameter int unsigned RAMP_CYC = 5,
  parameter int unsigned PARK_CYC = 3
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Commands from bench
  input  wire logic up_i,
  input  wire logic fail_i,
  // Device side
  input  wire logic park_req_i,
  output logic      sense_o,
  output logic      warn_o,
  output logic      park_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ramp;
  logic [7:0] pcnt;
  logic       supplies_ok;

  // Sense only after every supply has ramped up
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !up_i)
    begin
      ramp        <= 8'h00;
      supplies_ok <= 1'b0;
      sense_o     <= 1'b0;
    end
    else
    begin
      if (ramp != RAMP_CYC[7:0])
        ramp <= ramp + 8'h01;
      else
        supplies_ok <= 1'b1;
      sense_o <= supplies_ok;
    end
  end

  // Mirror parking takes a few cycles, never instant
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !park_req_i)
      pcnt <= 8'h00;
    else if (pcnt != PARK_CYC[7:0])
      pcnt <= pcnt + 8'h01;
    park_done_o <= !rst_i && park_req_i && (pcnt == PARK_CYC[7:0]);
    warn_o      <= !rst_i && fail_i;
  end
endmodule

`default_nettype wire

// *** verif/prs_sequencer_tb.sv ***
`default_nettype none

module prs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import prs_pkg::*;

  localparam int unsigned LOCK = 20;

  logic        clk_i, rst_i, up, fail, sys_req;
  logic        sense, warn, park_req, park_done;
  logic        pll_rst, cpu_rst, cpu_clk, io_oe;
  prs_wb_req_t wb_req;
  prs_wb_rsp_t wb_rsp;
  prs_dom_t    dom;
  logic [31:0] q;
  int          n;
  int          n_errors = 0;
  int          checks = 0;

  prs_sequencer #(.LOCK_CYC(LOCK)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .power_on_sense_i(sense), .supply_fail_warning_i(warn), .sys_reset_req_i(sys_req),
    .park_done_i(park_done), .park_req_o(park_req), .wb_i(wb_req), .wb_o(wb_rsp),
    .master_pll_rst_o(pll_rst), .cpu_rst_o(cpu_rst), .cpu_clk_en_o(cpu_clk),
    .io_oe_o(io_oe), .dom_o(dom));

  prs_pwr_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .up_i(up), .fail_i(fail),
    .park_req_i(park_req), .sense_o(sense), .warn_o(warn), .park_done_o(park_done));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ****************************
  // Helpers
  // ****************************
  task summarize;
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Settled values, one step past the edge
  task tick;
    @(posedge clk_i);
    #1;
  endtask

  task limit(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      n_errors++;
      $display("MISMATCH wait expected done seen timeout");
      summarize();
    end
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_rsp.ack !== 1'b1 && k < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    limit(k, 20);
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task t_powerup;
    repeat (3) tick();
    chk("pll_rst off", pll_rst, 1);
    chk("io_oe off", io_oe, 0);
    @(posedge clk_i);
    up <= 1'b1;
    n = 0;
    do begin tick(); n++; end while (sense !== 1'b1 && n < 50);
    limit(n, 50);
    n = 0;
    do begin tick(); n++; end while (pll_rst !== 1'b0 && n < 10);
    chk("sense to pll", n, 3);
    chk("cpu_rst lock", cpu_rst, 1);
    chk("io_oe lock", io_oe, 0);
    n = 0;
    do begin tick(); n++; end while (cpu_rst !== 1'b0 && n < 2 * LOCK);
    chk("lock cycles", n, LOCK);
    chk("cpu_clk", cpu_clk, 1);
    chk("io_oe run", io_oe, 1);
    chk("dom", {dom.clk_en, dom.blk_rst, dom.pgate_en, dom.pwr18_en},
        {CLKEN_RST, ~BLKREL_RST, PGATE_RST, 1'b1});
  endtask

  task t_regs;
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status", q, 32'h21);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h6);
    tick();
    chk("dram early", dom.dram_init, 0);
    wb(1'b1, OFS_CLKRST, 32'h0101);
    tick();
    chk("clkrst", {dom.clk_en, dom.blk_rst}, 16'h01fe);
    wb(1'b0, OFS_CLKRST, 32'h0);
    chk("clkrst rd", q, 32'h0101);
    wb(1'b0, OFS_PGATE, 32'h0);
    chk("pgate dflt", q, {24'h0, PGATE_RST});
    // Non-default gating so the warm reset has something to restore
    wb(1'b1, OFS_PGATE, 32'h0f);
    wb(1'b0, OFS_PGATE, 32'h0);
    chk("pgate rd", q, 32'h0f);
    wb(1'b1, OFS_CTRL, 32'h6);
    tick();
    chk("dram", dom.dram_init, 1);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl rd", q, 32'h6);
  endtask

  task t_warm(input logic lp, input logic exp18);
    if (lp)
      wb(1'b1, OFS_CTRL, 32'h1);
    @(posedge clk_i);
    sys_req <= 1'b1;
    @(posedge clk_i);
    sys_req <= 1'b0;
    tick();
    chk("warm cpu_rst", cpu_rst, 1);
    chk("warm dom", {dom.clk_en, dom.blk_rst, dom.pgate_en, dom.pwr18_en, dom.dram_init},
        {CLKEN_RST, ~BLKREL_RST, PGATE_RST, exp18, 1'b0});
    n = 0;
    do begin tick(); n++; end while (cpu_rst !== 1'b0 && n < 40);
    limit(n, 40);
    chk("hold", n, HOLD_CYC - 1);
    chk("pwr18 kept", dom.pwr18_en, exp18);
    if (lp)
    begin
      wb(1'b1, OFS_CTRL, 32'h2);
      tick();
      chk("pwr18 sw", dom.pwr18_en, 1);
    end
  endtask

  task t_fail;
    @(posedge clk_i);
    fail <= 1'b1;
    n = 0;
    do begin tick(); n++; end while (park_req !== 1'b1 && n < 10);
    limit(n, 10);
    chk("park first", cpu_rst, 0);
    n = 0;
    do begin tick(); n++; end while (cpu_rst !== 1'b1 && n < 20);
    limit(n, 20);
    chk("park over", park_req, 0);
    @(posedge clk_i);
    fail <= 1'b0;
    n = 0;
    do begin tick(); n++; end while (cpu_rst !== 1'b0 && n < 40);
    limit(n, 40);
  endtask

  task t_down;
    @(posedge clk_i);
    up <= 1'b0;
    n = 0;
    do begin tick(); n++; end while (io_oe !== 1'b0 && n < 10);
    chk("down io_oe", io_oe, 0);
    chk("down pll", pll_rst, 1);
    chk("down cpu", cpu_rst, 1);
  endtask

  initial
  begin
    rst_i   = 1'b1;
    up      = 1'b0;
    fail    = 1'b0;
    sys_req = 1'b0;
    wb_req  = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_powerup();
    t_regs();
    t_warm(1'b1, 1'b0);
    t_warm(1'b0, 1'b1);
    t_fail();
    t_down();
    summarize();
  end
endmodule

`default_nettype wire
